// ### logic/ist_pkg.sv
// Shared constants and types of the I2C target engine
package ist_pkg;
    // Fixed upper five bits of a 10-bit high address byte
    localparam logic [4:0] IST_HIGH_PATTERN = 5'h1E;
    // Bit count that marks a complete received byte
    localparam logic [3:0] IST_RX_LAST = 4'h8;
    // Bit count of the last transmitted data bit
    localparam logic [3:0] IST_TX_LAST = 4'h7;
    // Reset values
    localparam logic [7:0] IST_ADDR_RST = 8'h00;
    localparam logic [7:0] IST_BUF_RST = 8'h00;
    localparam logic IST_CKP_RST = 1'b1;
    // Engine states, one-hot
    typedef enum logic [4:0] {
        IST_IDLE = 5'h01,
        IST_RX = 5'h02,
        IST_ACK = 5'h04,
        IST_TX = 5'h08,
        IST_TXACK = 5'h10
    } ist_state_t;
endpackage

// ### logic/ist_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module ist_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstInt_n,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage_reg;

    // Refuse an empty vector
    if (WIDTH < 1) begin : gWidthCheck
        $error("ist_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            stage_reg <= '1;
            syncOut <= '1;
        end else begin
            stage_reg <= asyncIn;
            syncOut <= stage_reg;
        end
    end
endmodule

// ### logic/ist_cond_det.sv
// Bus clock edge and Start/Stop condition detector
`timescale 1ns/1ps
module ist_cond_det (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstInt_n,
    // Synchronised bus levels
    input wire logic sclS,
    input wire logic sdaS,
    // Events, one cycle each
    output logic sclRise,
    output logic sclFall,
    output logic startDet,
    output logic stopDet
);
    logic sclPrev_reg;
    logic sdaPrev_reg;

    // Previous levels
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= sclS;
            sdaPrev_reg <= sdaS;
        end
    end

    // Data edges while the clock stays high are conditions
    assign sclRise = sclS && !sclPrev_reg;
    assign sclFall = !sclS && sclPrev_reg;
    assign startDet = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
    assign stopDet = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
endmodule

// ### logic/ist_target.sv
// I2C target engine: addressing, receive, transmit, stretching
`timescale 1ns/1ps
module ist_target (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus clock pin, open drain
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    // Bus data pin, open drain
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Configuration levels
    input wire logic tenBitMode,
    input wire logic stretchEnable,
    input wire logic addressHoldEnable,
    input wire logic dataHoldEnable,
    input wire logic bufferOverwriteEnable,
    input wire logic targetCollisionDetectEnable,
    input wire logic startIrqEnable,
    input wire logic stopIrqEnable,
    input wire logic ackValueSelect,
    // Software strobes and data
    input wire logic ownAddressWrite,
    input wire logic [7:0] ownAddressData,
    input wire logic bufferWrite,
    input wire logic [7:0] bufferWriteData,
    input wire logic bufferRead,
    input wire logic irqClear,
    input wire logic overflowClear,
    input wire logic collisionClear,
    input wire logic clockReleaseSet,
    // Status
    output logic [7:0] ownAddressReg,
    output logic [7:0] shiftDataBuffer,
    output logic portIrqFlag,
    output logic collisionIrqFlag,
    output logic bufferFullFlag,
    output logic rxOverflowFlag,
    output logic updateAddressFlag,
    output logic readDirection,
    output logic startSeen,
    output logic stopSeen,
    output logic receivedAckStatus,
    output logic ackTimeFlag,
    output logic clockReleaseBit
);
    logic [1:0] rstSync_reg;
    logic rstInt_n;
    logic [1:0] pinSync;
    logic sclS;
    logic sdaS;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    ist_pkg::ist_state_t state_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] rxShift_reg;
    logic [7:0] txShift_reg;
    logic isAddr_reg;
    logic lowNext_reg;
    logic prior10_reg;
    logic curRead_reg;
    logic ackDrive_reg;
    logic holdAck_reg;
    logic accept;
    logic refuse;
    logic holdMode;
    logic byteDone;
    logic loadBuf;
    logic lowMiss;
    logic holdNow;
    logic ackEnd;
    logic ackGiven;
    logic txEnd;
    logic txFall;
    logic collide;
    logic tenHighByte;
    logic sawUpdate;

    // High address byte match in 10-bit mode
    function automatic logic highMatch(input logic [7:0] rxByte, input logic [7:0] own);
        highMatch = (rxByte[7:3] == ist_pkg::IST_HIGH_PATTERN) && (rxByte[2:1] == own[2:1]);
    endfunction

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstInt_n = rstSync_reg[1];

    // Pin synchronisers
    ist_sync #(.WIDTH(2)) uSync (
        .mclk(mclk),
        .rstInt_n(rstInt_n),
        .asyncIn({sclIn, sdaIn}),
        .syncOut(pinSync)
    );
    assign sclS = pinSync[1];
    assign sdaS = pinSync[0];

    // Edge and condition detection
    ist_cond_det uCond (
        .mclk(mclk),
        .rstInt_n(rstInt_n),
        .sclS(sclS),
        .sdaS(sdaS),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    // Byte decode and event terms
    always_comb begin
        tenHighByte = isAddr_reg && tenBitMode && !lowNext_reg;
        if (!isAddr_reg) begin
            accept = 1'b1;
        end else if (lowNext_reg) begin
            accept = (rxShift_reg == ownAddressReg);
        end else if (tenBitMode) begin
            accept = highMatch(rxShift_reg, ownAddressReg) && (!rxShift_reg[0] || prior10_reg);
        end else begin
            accept = (rxShift_reg[7:1] == ownAddressReg[7:1]);
        end
        refuse = (bufferFullFlag || rxOverflowFlag) && !bufferOverwriteEnable;
        holdMode = isAddr_reg ? addressHoldEnable : dataHoldEnable;
        byteDone = (state_reg == ist_pkg::IST_RX) && sclFall && (bitCnt_reg == ist_pkg::IST_RX_LAST);
        loadBuf = byteDone && accept && !refuse;
        lowMiss = byteDone && isAddr_reg && lowNext_reg && !accept;
        holdNow = byteDone && accept && holdMode;
        ackEnd = (state_reg == ist_pkg::IST_ACK) && sclFall;
        ackGiven = holdAck_reg ? !ackValueSelect : ackDrive_reg;
        txFall = (state_reg == ist_pkg::IST_TX) && sclFall;
        txEnd = (state_reg == ist_pkg::IST_TXACK) && sclFall;
        collide = (state_reg == ist_pkg::IST_TX) && sclRise && txShift_reg[7] && !sdaS;
        sawUpdate = (ackEnd && ackGiven && isAddr_reg && tenBitMode && !curRead_reg) || lowMiss;
    end

    // Sequence of the engine
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            state_reg <= ist_pkg::IST_IDLE;
            bitCnt_reg <= 4'h0;
            rxShift_reg <= 8'h00;
            isAddr_reg <= 1'b0;
            lowNext_reg <= 1'b0;
            curRead_reg <= 1'b0;
            ackDrive_reg <= 1'b0;
            holdAck_reg <= 1'b0;
        end else if (startDet) begin
            state_reg <= ist_pkg::IST_RX;
            bitCnt_reg <= 4'h0;
            isAddr_reg <= 1'b1;
            lowNext_reg <= 1'b0;
            curRead_reg <= 1'b0;
        end else if (stopDet) begin
            state_reg <= ist_pkg::IST_IDLE;
            lowNext_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ist_pkg::IST_IDLE: begin
                    bitCnt_reg <= 4'h0;
                end
                ist_pkg::IST_RX: begin
                    if (sclRise) begin
                        rxShift_reg <= {rxShift_reg[6:0], sdaS};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                    if (byteDone) begin
                        bitCnt_reg <= 4'h0;
                        state_reg <= accept ? ist_pkg::IST_ACK : ist_pkg::IST_IDLE;
                        ackDrive_reg <= !refuse;
                        holdAck_reg <= holdMode;
                        if (isAddr_reg && !lowNext_reg) begin
                            curRead_reg <= rxShift_reg[0];
                        end
                    end
                end
                ist_pkg::IST_ACK: begin
                    if (ackEnd) begin
                        if (!ackGiven) begin
                            state_reg <= ist_pkg::IST_IDLE;
                        end else if (curRead_reg) begin
                            state_reg <= ist_pkg::IST_TX;
                        end else begin
                            state_reg <= ist_pkg::IST_RX;
                        end
                        isAddr_reg <= tenHighByte && !curRead_reg;
                        lowNext_reg <= tenHighByte && !curRead_reg;
                    end
                end
                ist_pkg::IST_TX: begin
                    if (collide) begin
                        state_reg <= ist_pkg::IST_IDLE;
                    end else if (txFall) begin
                        if (bitCnt_reg == ist_pkg::IST_TX_LAST) begin
                            state_reg <= ist_pkg::IST_TXACK;
                            bitCnt_reg <= 4'h0;
                        end else begin
                            bitCnt_reg <= bitCnt_reg + 4'h1;
                        end
                    end
                end
                ist_pkg::IST_TXACK: begin
                    if (txEnd) begin
                        state_reg <= receivedAckStatus ? ist_pkg::IST_IDLE : ist_pkg::IST_TX;
                    end
                end
                default: begin
                    state_reg <= ist_pkg::IST_IDLE;
                end
            endcase
        end
    end

    // Prior 10-bit write match, kept across Restart
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            prior10_reg <= 1'b0;
        end else if (stopDet) begin
            prior10_reg <= 1'b0;
        end else if (ackEnd && ackGiven && isAddr_reg && lowNext_reg) begin
            prior10_reg <= 1'b1;
        end else if (byteDone && tenHighByte && !(highMatch(rxShift_reg, ownAddressReg) && rxShift_reg[0])) begin
            prior10_reg <= 1'b0;
        end
    end

    // Transmit shifter
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            txShift_reg <= 8'h00;
        end else if (bufferWrite) begin
            txShift_reg <= bufferWriteData;
        end else if (txFall) begin
            txShift_reg <= {txShift_reg[6:0], 1'b1};
        end
    end

    // Address, buffer and buffer flags
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            ownAddressReg <= ist_pkg::IST_ADDR_RST;
            shiftDataBuffer <= ist_pkg::IST_BUF_RST;
            bufferFullFlag <= 1'b0;
            rxOverflowFlag <= 1'b0;
            readDirection <= 1'b0;
        end else begin
            if (ownAddressWrite) begin
                ownAddressReg <= ownAddressData;
            end
            if (loadBuf) begin
                shiftDataBuffer <= rxShift_reg;
            end else if (bufferWrite) begin
                shiftDataBuffer <= bufferWriteData;
            end
            if (loadBuf || bufferWrite) begin
                bufferFullFlag <= 1'b1;
            end else if (bufferRead || (txFall && bitCnt_reg == ist_pkg::IST_TX_LAST)) begin
                bufferFullFlag <= 1'b0;
            end
            if (byteDone && accept && bufferFullFlag) begin
                rxOverflowFlag <= 1'b1;
            end else if (overflowClear) begin
                rxOverflowFlag <= 1'b0;
            end
            if (byteDone && accept && isAddr_reg && !lowNext_reg) begin
                readDirection <= rxShift_reg[0];
            end
        end
    end

    // Interrupt, update, collision and status flags
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            portIrqFlag <= 1'b0;
            collisionIrqFlag <= 1'b0;
            updateAddressFlag <= 1'b0;
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
            receivedAckStatus <= 1'b0;
            ackTimeFlag <= 1'b0;
        end else begin
            if ((startDet && startIrqEnable) || (stopDet && stopIrqEnable) || holdNow || lowMiss
                || (ackEnd && (!holdAck_reg || ackGiven)) || txEnd) begin
                portIrqFlag <= 1'b1;
            end else if (irqClear) begin
                portIrqFlag <= 1'b0;
            end
            if (collide && targetCollisionDetectEnable) begin
                collisionIrqFlag <= 1'b1;
            end else if (collisionClear) begin
                collisionIrqFlag <= 1'b0;
            end
            if (sawUpdate) begin
                updateAddressFlag <= 1'b1;
            end else if (ownAddressWrite) begin
                updateAddressFlag <= 1'b0;
            end
            if (startDet) begin
                startSeen <= 1'b1;
                stopSeen <= 1'b0;
            end else if (stopDet) begin
                startSeen <= 1'b0;
                stopSeen <= 1'b1;
            end
            if ((state_reg == ist_pkg::IST_TXACK) && sclRise) begin
                receivedAckStatus <= sdaS;
            end
            if (byteDone && accept && (addressHoldEnable || dataHoldEnable)) begin
                ackTimeFlag <= 1'b1;
            end else if (ackEnd || startDet || stopDet) begin
                ackTimeFlag <= 1'b0;
            end
        end
    end

    // Clock release bit: hardware clears, software sets
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            clockReleaseBit <= ist_pkg::IST_CKP_RST;
        end else if (clockReleaseSet) begin
            clockReleaseBit <= 1'b1;
        end else if (holdNow) begin
            clockReleaseBit <= 1'b0;
        end else if (ackEnd && ackGiven && curRead_reg) begin
            clockReleaseBit <= 1'b0;
        end else if (ackEnd && ackGiven && stretchEnable && !(isAddr_reg && tenBitMode)) begin
            clockReleaseBit <= 1'b0;
        end else if (txEnd && !receivedAckStatus) begin
            clockReleaseBit <= 1'b0;
        end
    end

    // Clock hold, taken only once the bus clock is low
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            sclOe <= 1'b0;
            sclOut <= 1'b0;
        end else begin
            sclOut <= 1'b0;
            sclOe <= (!clockReleaseBit || updateAddressFlag) && (!sclS || sclOe);
        end
    end

    // Data drive: acknowledge and transmit bits
    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
            if (startDet || stopDet || collide) begin
                sdaOe <= 1'b0;
            end else if (byteDone) begin
                sdaOe <= accept && !refuse && !holdMode;
            end else if (ackEnd) begin
                sdaOe <= ackGiven && curRead_reg && !txShift_reg[7];
            end else if (txFall) begin
                sdaOe <= (bitCnt_reg != ist_pkg::IST_TX_LAST) && !txShift_reg[6];
            end else if (state_reg == ist_pkg::IST_ACK) begin
                sdaOe <= ackGiven;
            end else if ((state_reg == ist_pkg::IST_TX) && !sclS) begin
                sdaOe <= !txShift_reg[7];
            end else if (state_reg != ist_pkg::IST_TX) begin
                sdaOe <= 1'b0;
            end
        end
    end
endmodule

// ### tb/ist_assertions.sv
// Port checker of the I2C target engine
`timescale 1ns/1ps
module ist_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus pins
    input wire logic sclIn,
    input wire logic sclOe,
    input wire logic sdaOe,
    // Software side
    input wire logic targetCollisionDetectEnable,
    input wire logic ownAddressWrite,
    input wire logic bufferWrite,
    input wire logic [7:0] bufferWriteData,
    input wire logic irqClear,
    input wire logic clockReleaseSet,
    // Status
    input wire logic [7:0] shiftDataBuffer,
    input wire logic portIrqFlag,
    input wire logic collisionIrqFlag,
    input wire logic bufferFullFlag,
    input wire logic updateAddressFlag,
    input wire logic startSeen,
    input wire logic stopSeen,
    input wire logic ackTimeFlag,
    input wire logic clockReleaseBit
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Bus and flag relations
    a_sda_low_move: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data moved, clock high");
    a_ua_cleared: assert property (ownAddressWrite |=> !updateAddressFlag)
        else $error("update flag kept");
    a_scl_freed: assert property (sclOe && clockReleaseBit && !updateAddressFlag |=> !sclOe)
        else $error("clock held after release");
    a_scl_cause: assert property ($rose(sclOe) |-> !$past(clockReleaseBit) || $past(updateAddressFlag))
        else $error("clock held without cause");
    a_ckp_set: assert property (clockReleaseSet |=> clockReleaseBit)
        else $error("release bit not set");
    a_irq_sticky: assert property (portIrqFlag && !irqClear |=> portIrqFlag)
        else $error("interrupt flag lost");
    a_buf_load: assert property (bufferWrite |=> bufferFullFlag && shiftDataBuffer == $past(bufferWriteData))
        else $error("buffer write not taken");
    a_hold_irq: assert property ($rose(ackTimeFlag) |-> portIrqFlag && !clockReleaseBit)
        else $error("hold without stretch");
    a_start_stop: assert property (!(startSeen && stopSeen))
        else $error("start and stop both seen");
    a_clash_gate: assert property ($rose(collisionIrqFlag) |-> $past(targetCollisionDetectEnable) && !sdaOe)
        else $error("stray collision flag");
    // Main scenarios reached
    c_update: cover property ($rose(updateAddressFlag));
    c_clash: cover property ($rose(collisionIrqFlag));
    c_hold: cover property ($rose(ackTimeFlag));
endmodule

// ### tb/ist_master_model.sv
// Behavioural I2C bus master on the far side of the target
`timescale 1ns/1ps
module ist_master_model (
    // Wired bus levels
    input wire logic sclLine,
    input wire logic sdaLine,
    // Pulls, high drives the line low
    output logic sclLow,
    output logic sdaLow,
    // Stretch wait ran out
    output logic hangSeen
);
    initial {sclLow, sdaLow, hangSeen} = 3'h0;
    // Release clock, bounded wait on stretch
    task automatic rise();
        int n;
        n = 0;
        sclLow = 1'b0;
        while (sclLine !== 1'b1 && n < 4000) begin
            #40;
            n++;
        end
        if (n == 4000) hangSeen = 1'b1;
    endtask
    // One bit: set while low, sampled late while high
    task automatic bitx(input logic b, output logic r);
        #80 sdaLow = !b;
        #80 rise();
        #160 r = sdaLine;
        sclLow = 1'b1;
    endtask
    // Start or restart
    task automatic start();
        #80 sdaLow = 1'b0;
        #80 rise();
        #80 sdaLow = 1'b1;
        #80 sclLow = 1'b1;
    endtask
    // Stop, bus left idle
    task automatic stop();
        #80 sdaLow = 1'b1;
        #80 rise();
        #80 sdaLow = 1'b0;
        #160;
    endtask
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    // Read a byte; pull marks bits forced low against the target
    task automatic recvByte(input logic ack, input logic [7:0] pull, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(!pull[i], r);
            d[i] = r;
        end
        bitx(!ack, r);
    endtask
endmodule

// ### tb/tb.sv
// Self-checking bench of the I2C target engine
`timescale 1ns/1ps
module tb;
    logic mclk, rst_n, tenBitMode, stretchEnable, addressHoldEnable, dataHoldEnable;
    logic bufferOverwriteEnable, targetCollisionDetectEnable, startIrqEnable, stopIrqEnable;
    logic ackValueSelect, ownAddressWrite, bufferWrite, bufferRead, irqClear, overflowClear;
    logic collisionClear, clockReleaseSet, sclOut, sclOe, sdaOut, sdaOe, mScl, mSda, hang, ack;
    logic portIrqFlag, collisionIrqFlag, bufferFullFlag, rxOverflowFlag, updateAddressFlag;
    logic readDirection, startSeen, stopSeen, receivedAckStatus, ackTimeFlag, clockReleaseBit;
    logic [7:0] ownAddressData, bufferWriteData, ownAddressReg, shiftDataBuffer, rd;
    int error_cnt, cmp_count;
    // Wired-and bus with pull-ups
    wire sclIn = !(sclOe || mScl);
    wire sdaIn = !(sdaOe || mSda);
    ist_target dut_u (.*);
    ist_master_model m_u (.sclLine(sclIn), .sdaLine(sdaIn), .sclLow(mScl), .sdaLow(mSda), .hangSeen(hang));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("%0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(posedge mclk) #1 s = 1'b1;
        @(posedge mclk) #1 s = 1'b0;
    endtask
    task automatic setOwn(input logic [7:0] a);
        ownAddressData = a;
        pulse(ownAddressWrite);
    endtask
    task automatic loadTx(input logic [7:0] d);
        bufferWriteData = d;
        pulse(bufferWrite);
        pulse(clockReleaseSet);
    endtask
    // Bounded wait for interrupt, then clear
    task automatic waitIrq();
        int n;
        n = 0;
        while (portIrqFlag !== 1'b1) begin
            #40 n++;
            if (n == 3000) begin
                error_cnt++;
                summarize();
            end
        end
        pulse(irqClear);
    endtask
    task automatic ending(input string s);
        if (hang) begin
            error_cnt++;
            summarize();
        end
        $display("%s finished", s);
    endtask
    task automatic t7Write();
        stretchEnable = 1'b1;
        setOwn(8'hA4);
        fork
            begin
                m_u.start();
                m_u.sendByte(8'hA4, ack);
                chk(ack, 1'b1);
                m_u.sendByte(8'h3C, ack);
                chk(ack, 1'b1);
                m_u.sendByte(8'h55, ack);
                chk(ack, 1'b0);
                m_u.stop();
            end
            begin
                waitIrq();
                chk({startSeen, readDirection, bufferFullFlag, clockReleaseBit, sclOe}, 8'h15);
                chk(shiftDataBuffer, 8'hA4);
                pulse(bufferRead);
                pulse(clockReleaseSet);
                waitIrq();
                pulse(clockReleaseSet);
                waitIrq();
                chk(shiftDataBuffer, 8'h3C);
                chk(rxOverflowFlag, 1'b1);
                pulse(clockReleaseSet);
            end
        join
        chk(stopSeen, 1'b1);
        pulse(bufferRead);
        pulse(overflowClear);
        ending("7-bit write");
    endtask
    task automatic t7Read();
        fork
            begin
                m_u.start();
                m_u.sendByte(8'hA6, ack);
                chk(ack, 1'b0);
                m_u.start();
                m_u.sendByte(8'hA5, ack);
                chk(ack, 1'b1);
                m_u.recvByte(1'b1, 8'h00, rd);
                chk(rd, 8'hC3);
                m_u.recvByte(1'b0, 8'h00, rd);
                chk(rd, 8'h5A);
                m_u.stop();
            end
            begin
                waitIrq();
                chk({readDirection, clockReleaseBit, sclOe}, 8'h05);
                chk(shiftDataBuffer, 8'hA5);
                pulse(bufferRead);
                loadTx(8'hC3);
                waitIrq();
                chk({receivedAckStatus, clockReleaseBit, sclOe}, 8'h01);
                loadTx(8'h5A);
                waitIrq();
                chk({receivedAckStatus, sclOe}, 8'h02);
            end
        join
        ending("7-bit read");
    endtask
    task automatic t10();
        tenBitMode = 1'b1;
        stretchEnable = 1'b0;
        setOwn(8'h04);
        fork
            begin
                m_u.start();
                m_u.sendByte(8'hF4, ack);
                chk(ack, 1'b1);
                m_u.sendByte(8'hB6, ack);
                chk(ack, 1'b0);
                m_u.start();
                m_u.sendByte(8'hF4, ack);
                m_u.sendByte(8'hB5, ack);
                chk(ack, 1'b1);
                m_u.start();
                m_u.sendByte(8'hF5, ack);
                chk(ack, 1'b1);
                m_u.recvByte(1'b0, 8'h00, rd);
                chk(rd, 8'h96);
                m_u.stop();
            end
            begin
                waitIrq();
                chk({updateAddressFlag, sclOe}, 8'h03);
                pulse(bufferRead);
                setOwn(8'hB5);
                waitIrq();
                chk({updateAddressFlag, bufferFullFlag, sclOe}, 8'h05);
                setOwn(8'h04);
                waitIrq();
                pulse(bufferRead);
                setOwn(8'hB5);
                waitIrq();
                chk(shiftDataBuffer, 8'hB5);
                pulse(bufferRead);
                setOwn(8'h04);
                #40 chk({updateAddressFlag, sclOe}, 8'h00);
                waitIrq();
                chk(readDirection, 1'b1);
                pulse(bufferRead);
                loadTx(8'h96);
                waitIrq();
            end
        join
        tenBitMode = 1'b0;
        ending("10-bit");
    endtask
    task automatic tHold();
        {addressHoldEnable, dataHoldEnable} = 2'h3;
        setOwn(8'hA4);
        fork
            begin
                m_u.start();
                m_u.sendByte(8'hA4, ack);
                chk(ack, 1'b1);
                m_u.sendByte(8'h77, ack);
                chk(ack, 1'b0);
                m_u.stop();
            end
            begin
                waitIrq();
                chk({ackTimeFlag, clockReleaseBit, sclOe}, 8'h05);
                pulse(bufferRead);
                ackValueSelect = 1'b0;
                pulse(clockReleaseSet);
                waitIrq();
                chk(ackTimeFlag, 1'b0);
                waitIrq();
                chk({ackTimeFlag, clockReleaseBit}, 8'h02);
                pulse(bufferRead);
                ackValueSelect = 1'b1;
                pulse(clockReleaseSet);
            end
        join
        chk(portIrqFlag, 1'b0);
        {addressHoldEnable, dataHoldEnable, ackValueSelect} = 3'h0;
        ending("hold");
    endtask
    task automatic tClash();
        targetCollisionDetectEnable = 1'b1;
        fork
            begin
                m_u.start();
                m_u.sendByte(8'hA5, ack);
                m_u.recvByte(1'b0, 8'h40, rd);
                chk(rd, 8'hBF);
                m_u.stop();
            end
            begin
                waitIrq();
                pulse(bufferRead);
                loadTx(8'hC0);
            end
        join
        chk({collisionIrqFlag, sclOe, sdaOe}, 8'h04);
        pulse(collisionClear);
        chk(collisionIrqFlag, 1'b0);
        ending("collision");
    endtask
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        {rst_n, tenBitMode, stretchEnable, addressHoldEnable, dataHoldEnable, bufferOverwriteEnable} = '0;
        {targetCollisionDetectEnable, startIrqEnable, stopIrqEnable, ackValueSelect, ownAddressWrite} = '0;
        {bufferWrite, bufferRead, irqClear, overflowClear, collisionClear, clockReleaseSet} = '0;
        {ownAddressData, bufferWriteData} = '0;
        repeat (20) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk(ownAddressReg, 8'h00);
        chk(clockReleaseBit, 1'b1);
        t7Write();
        t7Read();
        t10();
        tHold();
        tClash();
        summarize();
    end
endmodule
bind ist_target ist_assertions chk_u (.*);
